// *** logic/ppcv_top.sv ***
`timescale 1ns/100ps
// Functional notes
// - Input mode 00 buffer on no pull, 01 pull-down, 10 pull-up, 11 buffer off.
// - A config read returns the mode of the saved pin, input or output per saved direction.
// - Direction bit 0 acts on output configuration and 1 on input configuration.
// - With save-for-read set, index and direction are stored and no mode changes.
// - With save-for-read clear, the addressed pin's selected mode takes the mode field.
// - Four 8-bit value registers reset to ff; reads give pin levels, writes set outputs.
// - Present pins depend on package variant; absent indices are reserved.
// - Output mode 000 is normal drive, 011 high drive, other codes illegal.
// - Config bit 4 is direction, bit 3 save-for-read, bits 2:0 pin index.
module ppcv_top #(
	parameter logic [31:0] PRESENT_MASK = 32'hffffffff
) (
	// Clock, reset, enable
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        clk_en,
	// AXI4-Lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Pins
	input  wire logic [31:0] pin_in,
	output logic      [31:0] pin_out,
	output logic      [95:0] pin_out_mode,
	output logic      [63:0] pin_in_mode
);
	logic [7:0]  awaddr_q, awaddr_d;
	logic        aw_full_q, aw_full_d;
	logic [7:0]  wdata_q, wdata_d;
	logic        wstb0_q, wstb0_d;
	logic        w_full_q, w_full_d;
	logic        bvalid_q, bvalid_d;
	logic [1:0]  bresp_q, bresp_d;
	logic        rvalid_q, rvalid_d;
	logic [1:0]  rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic [31:0] val_q, val_d;
	logic [31:0] sync1_q, sync2_q;
	logic        do_wr;
	logic        wr_ok;
	logic [3:0]  cfg_wr;
	logic [7:0]  cfg_rd [4];

	// Channel readiness: one write in flight, held until response taken.
	// Ready drops while the enable is low, since frozen registers could not take the item;
	// valid outputs hold their value then, so a master must not finish a response meanwhile.
	assign s_axi_awready = clk_en && !aw_full_q && !bvalid_q;
	assign s_axi_wready  = clk_en && !w_full_q && !bvalid_q;
	assign s_axi_arready = clk_en && !rvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;
	assign pin_out       = val_q;
	assign do_wr         = aw_full_q && w_full_q && !bvalid_q;

	// Address decode of the captured write
	always_comb
	begin
		wr_ok  = 1'b1;
		cfg_wr = 4'h0;
		case (awaddr_q)
			ppcv_pkg::PORT0_VALUES_OFF, ppcv_pkg::PORT1_VALUES_OFF,
			ppcv_pkg::PORT2_VALUES_OFF, ppcv_pkg::PORT3_VALUES_OFF,
			ppcv_pkg::PRESENT_OFF: wr_ok = 1'b1;
			ppcv_pkg::PORT0_CONFIG_OFF: cfg_wr[0] = do_wr && wstb0_q;
			ppcv_pkg::PORT1_CONFIG_OFF: cfg_wr[1] = do_wr && wstb0_q;
			ppcv_pkg::PORT2_CONFIG_OFF: cfg_wr[2] = do_wr && wstb0_q;
			ppcv_pkg::PORT3_CONFIG_OFF: cfg_wr[3] = do_wr && wstb0_q;
			default: wr_ok = 1'b0;
		endcase
	end

	// Write path next state
	always_comb
	begin
		awaddr_d  = awaddr_q;
		aw_full_d = aw_full_q;
		wdata_d   = wdata_q;
		wstb0_d   = wstb0_q;
		w_full_d  = w_full_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		val_d     = val_q;
		if (s_axi_awvalid && s_axi_awready)
		begin
			awaddr_d  = {s_axi_awaddr[7:2], 2'b00};
			aw_full_d = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			wdata_d  = s_axi_wdata[7:0];
			wstb0_d  = s_axi_wstrb[0];
			w_full_d = 1'b1;
		end
		if (do_wr)
		begin
			aw_full_d = 1'b0;
			w_full_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = wr_ok ? ppcv_pkg::RESP_OKAY : ppcv_pkg::RESP_SLVERR;
			if (wstb0_q)
			begin
				case (awaddr_q)
					ppcv_pkg::PORT0_VALUES_OFF: val_d[7:0]   = wdata_q;
					ppcv_pkg::PORT1_VALUES_OFF: val_d[15:8]  = wdata_q;
					ppcv_pkg::PORT2_VALUES_OFF: val_d[23:16] = wdata_q;
					ppcv_pkg::PORT3_VALUES_OFF: val_d[31:24] = wdata_q;
					default: val_d = val_q;
				endcase
			end
		end
		if (bvalid_q && s_axi_bready)
			bvalid_d = 1'b0;
	end

	// Read path next state: pin levels, not output latches, are returned
	always_comb
	begin
		rvalid_d = rvalid_q;
		rresp_d  = rresp_q;
		rdata_d  = rdata_q;
		if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_d = 1'b1;
			rresp_d  = ppcv_pkg::RESP_OKAY;
			rdata_d  = 32'h0;
			case ({s_axi_araddr[7:2], 2'b00})
				ppcv_pkg::PORT0_VALUES_OFF: rdata_d[7:0] = sync2_q[7:0];
				ppcv_pkg::PORT1_VALUES_OFF: rdata_d[7:0] = sync2_q[15:8];
				ppcv_pkg::PORT2_VALUES_OFF: rdata_d[7:0] = sync2_q[23:16];
				ppcv_pkg::PORT3_VALUES_OFF: rdata_d[7:0] = sync2_q[31:24];
				ppcv_pkg::PORT0_CONFIG_OFF: rdata_d[7:0] = cfg_rd[0];
				ppcv_pkg::PORT1_CONFIG_OFF: rdata_d[7:0] = cfg_rd[1];
				ppcv_pkg::PORT2_CONFIG_OFF: rdata_d[7:0] = cfg_rd[2];
				ppcv_pkg::PORT3_CONFIG_OFF: rdata_d[7:0] = cfg_rd[3];
				ppcv_pkg::PRESENT_OFF:      rdata_d      = PRESENT_MASK;
				default: rresp_d = ppcv_pkg::RESP_SLVERR;
			endcase
		end
		else if (rvalid_q && s_axi_rready)
			rvalid_d = 1'b0;
	end

	// Registers; synchroniser uses no enable-dependent logic beyond freezing
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awaddr_q  <= 8'h00;
			aw_full_q <= 1'b0;
			wdata_q   <= 8'h00;
			wstb0_q   <= 1'b0;
			w_full_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= ppcv_pkg::RESP_OKAY;
			rvalid_q  <= 1'b0;
			rresp_q   <= ppcv_pkg::RESP_OKAY;
			rdata_q   <= 32'h0;
			val_q     <= {ppcv_pkg::NUM_PORTS{ppcv_pkg::VALUES_RST}};
			sync1_q   <= 32'h0;
			sync2_q   <= 32'h0;
		end
		else if (clk_en)
		begin
			awaddr_q  <= awaddr_d;
			aw_full_q <= aw_full_d;
			wdata_q   <= wdata_d;
			wstb0_q   <= wstb0_d;
			w_full_q  <= w_full_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			rvalid_q  <= rvalid_d;
			rresp_q   <= rresp_d;
			rdata_q   <= rdata_d;
			val_q     <= val_d;
			sync1_q   <= pin_in;
			sync2_q   <= sync1_q;
		end
	end

	// One configuration unit per port, absent pins masked per variant
	for (genvar p = 0; p < ppcv_pkg::NUM_PORTS; p++)
	begin : g_port
		ppcv_port_cfg #(
			.PRESENT (PRESENT_MASK[8*p +: 8])
		) u_cfg (
			.aclk     (aclk),
			.aresetn  (aresetn),
			.clk_en   (clk_en),
			.wr_stb   (cfg_wr[p]),
			.wr_data  (wdata_q),
			.rd_data  (cfg_rd[p]),
			.out_mode (pin_out_mode[24*p +: 24]),
			.in_mode  (pin_in_mode[16*p +: 16])
		);
	end

	// Bus and value checks
	a_value_reset: assert property (@(posedge aclk)
		$rose(aresetn) |-> pin_out == 32'hffffffff)
		else $error("port values not ff after reset");
	a_value_write: assert property (@(posedge aclk) disable iff (!aresetn)
		(clk_en && do_wr && wstb0_q && awaddr_q == ppcv_pkg::PORT2_VALUES_OFF)
		|=> pin_out[23:16] == $past(wdata_q))
		else $error("port value write lost");
	a_resp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
		else $error("write response dropped");
	a_ready_frozen: assert property (@(posedge aclk) disable iff (!aresetn)
		!clk_en |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
		else $error("bus ready while enable low");
	c_write: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);
	c_read: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
endmodule

// *** shared/ppcv_pkg.sv ***
package ppcv_pkg;
	// Byte addresses of the port value registers
	localparam logic [7:0] PORT0_VALUES_OFF = 8'h80;
	localparam logic [7:0] PORT1_VALUES_OFF = 8'h90;
	localparam logic [7:0] PORT2_VALUES_OFF = 8'ha0;
	localparam logic [7:0] PORT3_VALUES_OFF = 8'hb0;
	// Configuration registers, one per port
	localparam logic [7:0] PORT0_CONFIG_OFF = 8'hc0;
	localparam logic [7:0] PORT1_CONFIG_OFF = 8'hc4;
	localparam logic [7:0] PORT2_CONFIG_OFF = 8'hc8;
	localparam logic [7:0] PORT3_CONFIG_OFF = 8'hcc;
	// Package variant mask register (present pins, read only)
	localparam logic [7:0] PRESENT_OFF      = 8'hd0;
	// Field positions in a configuration write
	localparam int MODE_HI   = 7;
	localparam int MODE_LO   = 5;
	localparam int INMODE_HI = 6;
	localparam int DIR_BIT   = 4;
	localparam int SAVE_BIT  = 3;
	localparam int IDX_HI    = 2;
	// Reset values
	localparam logic [7:0] VALUES_RST  = 8'hff;
	localparam logic [2:0] OUTMODE_RST = 3'h0;
	localparam logic [1:0] INMODE_RST  = 2'h0;
	// Mode encodings
	localparam logic [2:0] OUT_NORMAL  = 3'h0;
	localparam logic [2:0] OUT_HIGH    = 3'h3;
	localparam logic [1:0] IN_NOPULL   = 2'h0;
	localparam logic [1:0] IN_PULLDOWN = 2'h1;
	localparam logic [1:0] IN_PULLUP   = 2'h2;
	localparam logic [1:0] IN_OFF      = 2'h3;
	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int NUM_PORTS = 4;
endpackage

// *** logic/ppcv_port_cfg.sv ***
`timescale 1ns/100ps
// Configuration of one 8-pin port behind an indirect register
module ppcv_port_cfg #(
	parameter logic [7:0] PRESENT = 8'hff
) (
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       clk_en,
	// Write and read view
	input  wire logic       wr_stb,
	input  wire logic [7:0] wr_data,
	output logic      [7:0] rd_data,
	// Per-pin mode outputs
	output logic      [23:0] out_mode,
	output logic      [15:0] in_mode
);
	logic [2:0] om_q [8];
	logic [2:0] om_d [8];
	logic [1:0] im_q [8];
	logic [1:0] im_d [8];
	logic [2:0] sel_q;
	logic [2:0] sel_d;
	logic       dir_q;
	logic       dir_d;
	logic [2:0] idx;
	logic       save;
	logic       dir;
	assign idx  = wr_data[ppcv_pkg::IDX_HI:0];
	assign save = wr_data[ppcv_pkg::SAVE_BIT];
	assign dir  = wr_data[ppcv_pkg::DIR_BIT];

	// Next state: either latch the read pointer or update one pin
	always_comb
	begin
		om_d  = om_q;
		im_d  = im_q;
		sel_d = sel_q;
		dir_d = dir_q;
		if (wr_stb)
		begin
			if (save)
			begin
				sel_d = idx;
				dir_d = dir;
			end
			else if (PRESENT[idx])
			begin
				if (dir)
					im_d[idx] = wr_data[ppcv_pkg::INMODE_HI:ppcv_pkg::MODE_LO];
				else
					om_d[idx] = wr_data[ppcv_pkg::MODE_HI:ppcv_pkg::MODE_LO];
			end
		end
	end

	// State registers; enable freezes everything
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < 8; i++)
			begin
				om_q[i] <= ppcv_pkg::OUTMODE_RST;
				im_q[i] <= ppcv_pkg::INMODE_RST;
			end
			sel_q <= 3'h0;
			dir_q <= 1'b0;
		end
		else if (clk_en)
		begin
			om_q  <= om_d;
			im_q  <= im_d;
			sel_q <= sel_d;
			dir_q <= dir_d;
		end
	end

	// Read back mode of the saved pin, in the mode field position
	always_comb
	begin
		rd_data = 8'h00;
		if (dir_q)
			rd_data[ppcv_pkg::INMODE_HI:ppcv_pkg::MODE_LO] = im_q[sel_q];
		else
			rd_data[ppcv_pkg::MODE_HI:ppcv_pkg::MODE_LO] = om_q[sel_q];
		rd_data[ppcv_pkg::DIR_BIT] = dir_q;
		rd_data[ppcv_pkg::IDX_HI:0] = sel_q;
	end

	// Flatten modes for the pad ring
	for (genvar g = 0; g < 8; g++)
	begin : g_flat
		assign out_mode[3*g +: 3] = om_q[g];
		assign in_mode[2*g +: 2]  = im_q[g];
	end

	// Rule checks
	a_save_keeps_mode: assert property (@(posedge aclk) disable iff (!aresetn)
		(clk_en && wr_stb && save) |=> $stable(out_mode) && $stable(in_mode))
		else $error("save write changed a pin mode");
	a_save_sets_ptr: assert property (@(posedge aclk) disable iff (!aresetn)
		(clk_en && wr_stb && save) |=> (sel_q == $past(idx)) && (dir_q == $past(dir)))
		else $error("save write did not store pointer");
	a_in_update: assert property (@(posedge aclk) disable iff (!aresetn)
		(clk_en && wr_stb && !save && dir && PRESENT[idx])
		|=> im_q[$past(idx)] == $past(wr_data[6:5]))
		else $error("input mode not updated");
	a_out_update: assert property (@(posedge aclk) disable iff (!aresetn)
		(clk_en && wr_stb && !save && !dir && PRESENT[idx])
		|=> om_q[$past(idx)] == $past(wr_data[7:5]))
		else $error("output mode not updated");
	a_absent_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
		(clk_en && wr_stb && !save && !PRESENT[idx]) |=> $stable(out_mode) && $stable(in_mode))
		else $error("absent pin changed");
	a_read_input: assert property (@(posedge aclk) disable iff (!aresetn)
		dir_q |-> rd_data[6:5] == in_mode[2*sel_q +: 2] && !rd_data[7])
		else $error("input mode readback wrong");
	c_save: cover property (@(posedge aclk) clk_en && wr_stb && save);
	c_in_wr: cover property (@(posedge aclk) clk_en && wr_stb && !save && dir);
	c_out_wr: cover property (@(posedge aclk) clk_en && wr_stb && !save && !dir);
endmodule

// *** test/ppcv_tb_top.sv ***
`timescale 1ns/100ps
// Compare one design value against its expectation and count the result
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin err_total++; \
	$display("ERROR %s expected %h seen %h", nm, ex, gt); end end
module ppcv_tb_top;
	// Port 3 pin 7 absent, as in a smaller package variant
	localparam logic [31:0] MASK = 32'h7fffffff;
	logic        aclk, aresetn, clk_en;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata, pin_in, pin_out;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [95:0] pin_out_mode, exp_om;
	logic [63:0] pin_in_mode, exp_im;
	logic [31:0] rd, po;
	logic [7:0]  d;
	logic [2:0]  om [4][8];
	logic [1:0]  im [4][8];
	logic [2:0]  sidx [4];
	logic        sdir [4];
	int          err_total, checked, cyc;

	ppcv_top #(.PRESENT_MASK(MASK)) DUT (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pin_in(pin_in),
		.pin_out(pin_out), .pin_out_mode(pin_out_mode), .pin_in_mode(pin_in_mode));

	// 10 MHz clock
	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// Hang guard, well above the under two thousand cycles the run needs
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			summarize();
		end
	end

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Write with address and data offered together; ready is sampled at the
	// negedge, which equals its value at the next edge since inputs hold still
	task automatic axi_wr(input logic [7:0] a, input logic [7:0] v, input logic st);
		logic aw, w, b;
		logic [31:0] rv;
		b = 1'b0;
		rv = $urandom();
		s_axi_awaddr <= a;
		s_axi_wdata <= {rv[31:8], v};
		s_axi_wstrb <= {rv[3:1], st};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b)
		begin
			@(negedge aclk);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (b) s_axi_bready <= 1'b0;
		end
		// Let an edge pass so a following call never reassigns bready in this step
		@(posedge aclk);
	endtask

	task automatic axi_rd(input logic [7:0] a);
		logic ar, b;
		b = 1'b0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!b)
		begin
			@(negedge aclk);
			ar = s_axi_arvalid && s_axi_arready;
			b = s_axi_rvalid;
			rd = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ar) s_axi_arvalid <= 1'b0;
			if (b) s_axi_rready <= 1'b0;
		end
		// Same spacing as the write task
		@(posedge aclk);
	endtask

	// Expected config read: saved pin's mode per saved direction
	function automatic logic [7:0] exp_cfg(input int p);
		if (sdir[p])
			return {1'b0, im[p][sidx[p]], 2'b10, sidx[p]};
		return {om[p][sidx[p]], 2'b00, sidx[p]};
	endfunction

	// Config write, reference update, then full mode vector and read-back check
	task automatic cfg_wr(input int p, input logic [7:0] v);
		axi_wr(ppcv_pkg::PORT0_CONFIG_OFF + 8'(4 * p), v, 1'b1);
		`CHK("config bresp", ppcv_pkg::RESP_OKAY, r)
		if (v[3])
		begin
			sidx[p] = v[2:0];
			sdir[p] = v[4];
		end
		else if (MASK[8 * p + int'(v[2:0])])
		begin
			if (v[4]) im[p][v[2:0]] = v[6:5];
			else om[p][v[2:0]] = v[7:5];
		end
		@(negedge aclk);
		for (int q = 0; q < 4; q++)
			for (int k = 0; k < 8; k++)
			begin
				exp_om[24 * q + 3 * k +: 3] = om[q][k];
				exp_im[16 * q + 2 * k +: 2] = im[q][k];
			end
		`CHK("pin_out_mode", exp_om, pin_out_mode)
		`CHK("pin_in_mode", exp_im, pin_in_mode)
		@(posedge aclk);
		axi_rd(ppcv_pkg::PORT0_CONFIG_OFF + 8'(4 * p));
		`CHK("config read", {24'h0, exp_cfg(p)}, rd)
	endtask

	initial
	begin
		aresetn = 1'b0;
		clk_en = 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		pin_in = 32'h0;
		rd = $urandom(32'h3c7d);
		for (int q = 0; q < 4; q++)
		begin
			sidx[q] = 3'h0;
			sdir[q] = 1'b0;
			for (int k = 0; k < 8; k++)
			begin
				om[q][k] = ppcv_pkg::OUTMODE_RST;
				im[q][k] = ppcv_pkg::INMODE_RST;
			end
		end
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		`CHK("pin_out reset", {4{ppcv_pkg::VALUES_RST}}, pin_out)
		`CHK("out mode reset", 96'h0, pin_out_mode)
		@(posedge aclk);
		// Enable low: the write stalls and no state moves until enable returns
		clk_en <= 1'b0;
		fork
			axi_wr(ppcv_pkg::PORT0_VALUES_OFF, 8'h00, 1'b1);
			begin
				repeat (5) @(posedge aclk);
				`CHK("frozen pin_out", {4{ppcv_pkg::VALUES_RST}}, pin_out)
				clk_en <= 1'b1;
			end
		join
		`CHK("pin_out after enable", 32'hffffff00, pin_out)
		po = {4{ppcv_pkg::VALUES_RST}};
		// Output values per port, then a write with strobe low that must not land
		for (int q = 0; q < 4; q++)
		begin
			d = 8'($urandom());
			po[8 * q +: 8] = d;
			axi_wr(ppcv_pkg::PORT0_VALUES_OFF + 8'(16 * q), d, 1'b1);
		end
		axi_wr(ppcv_pkg::PORT1_VALUES_OFF, ~po[15:8], 1'b0);
		`CHK("pin_out", po, pin_out)
		// Value reads follow the synchronised pin levels
		pin_in <= $urandom();
		repeat (4) @(posedge aclk);
		for (int q = 0; q < 4; q++)
		begin
			axi_rd(ppcv_pkg::PORT0_VALUES_OFF + 8'(16 * q));
			`CHK("value read", {24'h0, pin_in[8 * q +: 8]}, rd)
		end
		// Unmapped place and the read-only variant mask
		axi_wr(8'h44, 8'h5a, 1'b1);
		`CHK("unmapped bresp", ppcv_pkg::RESP_SLVERR, r)
		axi_rd(8'h44);
		`CHK("unmapped rresp", ppcv_pkg::RESP_SLVERR, r)
		axi_rd(ppcv_pkg::PRESENT_OFF);
		`CHK("present mask", MASK, rd)
		// Every input code and both legal output codes on pin 2 of port 0
		for (int c = 0; c < 4; c++)
		begin
			cfg_wr(0, {1'b0, 2'(c), 5'h12});
			cfg_wr(0, {3'h0, 5'h1a});
		end
		cfg_wr(0, {ppcv_pkg::OUT_HIGH, 5'h02});
		cfg_wr(0, {3'h0, 5'h0a});
		cfg_wr(0, {ppcv_pkg::OUT_NORMAL, 5'h02});
		// Absent pin: mode writes vanish
		cfg_wr(3, {ppcv_pkg::OUT_HIGH, 5'h07});
		cfg_wr(3, {3'h0, 5'h1f});
		cfg_wr(3, {1'b0, ppcv_pkg::IN_OFF, 5'h17});
		// Random traffic with only legal output codes
		repeat (150)
		begin
			d = 8'($urandom());
			if (!d[4] && !d[3]) d[7:5] = d[7] ? ppcv_pkg::OUT_HIGH : ppcv_pkg::OUT_NORMAL;
			cfg_wr($urandom_range(0, 3), d);
		end
		summarize();
	end
endmodule
